// File: rtl/nvmac_defs.svh
// Offsets, field positions, reset values and timing counts of the access block
`ifndef NVMAC_DEFS_SVH
`define NVMAC_DEFS_SVH

// ==========================================================
// Register offsets
`define NVMAC_OFS_CTRL     2'h0
`define NVMAC_OFS_STATUS   2'h1
`define NVMAC_OFS_MASK     2'h2

// ==========================================================
// Control register fields
`define NVMAC_BIT_PGM      7
`define NVMAC_BIT_CFG      6
`define NVMAC_BIT_RSVD     5
`define NVMAC_BIT_ERASE    4
`define NVMAC_BIT_WERR     3
`define NVMAC_BIT_WRITE_ENABLE_BIT     2
`define NVMAC_BIT_WR       1
`define NVMAC_BIT_RD       0

// ==========================================================
// Event status fields and reset values
`define NVMAC_EVT_DONE     0
`define NVMAC_EVT_WERR     1
`define NVMAC_EVT_RST      2'h0
`define NVMAC_MASK_RST     2'h0

// ==========================================================
// Self-timed write length
`define NVMAC_CLK_HZ       20000000
`define NVMAC_WRITE_NS     4000000
`define NVMAC_WRITE_CYC    ((`NVMAC_WRITE_NS / 1000) * (`NVMAC_CLK_HZ / 1000000))
`define NVMAC_CNT_W        17

`endif

// File: rtl/nvmac_pkg.sv
// Types shared by the access block
package nvmac_pkg;

  typedef enum logic [1:0] {
    NVMAC_IDLE = 2'b01,
    NVMAC_BUSY = 2'b10
  } nvmac_state_t;

  typedef logic [1:0] nvmac_target_t;

endpackage : nvmac_pkg

// File: rtl/nvm_access_control.sv
// Control and status logic for nonvolatile memory read, write and erase
//
// Implementation choices: the strobed register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "nvmac_defs.svh"

// Overview of operation
// - With the memory-select bit set, operations go to flash program memory, else to EEPROM.
// - With the config-select bit set, operations go to the configuration registers instead.
// - With row-erase set, the next write erases the pointed row and row-erase clears at the end.
// - The write-error flag sets on a warm reset (coldStart low) during a write or an improper write attempt.
// - Write and erase cycles start only while the write-enable bit is one.
// - Setting write-control starts a self-timed cycle and hardware clears it when done.
// - Software can only set write-control; writing zero to it does nothing.
// - Setting read-control starts a one-cycle read and hardware then clears the bit.
// - Read-control cannot be set while memory-select or config-select is one.
// - A warm-reset write error leaves memory-select and config-select as they were; an improper attempt loads them from the written byte.
module nvm_access_control
  import nvmac_pkg::*;
#(
  parameter int unsigned WRITE_CYCLES = `NVMAC_WRITE_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        coldStart,
  input  wire logic [1:0]  regAddr,
  input  wire logic [7:0]  regWrData,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [7:0]  regRdData,
  input  wire logic [21:0] tablePointer,
  output logic             memReadStart,
  output logic             memWriteStart,
  output logic             memEraseStart,
  output logic             memBusy,
  output logic      [1:0]  memTarget,
  output logic      [21:0] memRowAddr,
  output logic             irq
);

  // ==========================================================
  // State
  nvmac_state_t             state_reg;
  nvmac_state_t             state_next;
  logic [`NVMAC_CNT_W-1:0]  cnt_reg;
  logic [`NVMAC_CNT_W-1:0]  cnt_next;
  logic                     selPgm_reg;
  logic                     selPgm_next;
  logic                     selCfg_reg;
  logic                     selCfg_next;
  logic                     rowErase_reg;
  logic                     rowErase_next;
  logic                     write_error_flag_reg;
  logic                     write_error_flag_next;
  logic                     write_enable_bit_reg;
  logic                     write_enable_bit_next;
  logic                     wrCtl_reg;
  logic                     wrCtl_next;
  logic                     rdCtl_reg;
  logic                     rdCtl_next;
  logic [1:0]               status_reg;
  logic [1:0]               status_next;
  logic [1:0]               mask_reg;
  logic [1:0]               mask_next;
  logic [7:0]               rdData_reg;
  logic [7:0]               rdData_next;
  logic                     irq_reg;
  logic                     irq_next;
  logic                     mRd_reg;
  logic                     mRd_next;
  logic                     mWr_reg;
  logic                     mWr_next;
  logic                     mEr_reg;
  logic                     mEr_next;
  nvmac_target_t            mTgt_reg;
  nvmac_target_t            mTgt_next;
  logic [21:0]              mAddr_reg;
  logic [21:0]              mAddr_next;
  logic                     rdCtlSeen_reg;

  logic                     ctrlWr;
  logic                     lastCnt;
  logic                     busy;
  logic [1:0]               events;

  function automatic logic [7:0] ctrlPack(
    input logic pgm,
    input logic cfg,
    input logic er,
    input logic err,
    input logic en,
    input logic wr,
    input logic rd
  );
    ctrlPack = {pgm, cfg, 1'b0, er, err, en, wr, rd};
  endfunction : ctrlPack

  assign ctrlWr  = regWrite && (regAddr == `NVMAC_OFS_CTRL);
  assign busy    = (state_reg == NVMAC_BUSY);
  assign lastCnt = (cnt_reg == `NVMAC_CNT_W'(WRITE_CYCLES - 1));

  // ==========================================================
  // Control register and sequencer
  always_comb begin
    state_next    = state_reg;
    cnt_next      = cnt_reg;
    selPgm_next   = selPgm_reg;
    selCfg_next   = selCfg_reg;
    rowErase_next = rowErase_reg;
    write_error_flag_next    = write_error_flag_reg;
    write_enable_bit_next     = write_enable_bit_reg;
    wrCtl_next    = wrCtl_reg;
    rdCtl_next    = 1'b0;
    mRd_next      = 1'b0;
    mWr_next      = 1'b0;
    mEr_next      = 1'b0;
    mTgt_next     = mTgt_reg;
    mAddr_next    = mAddr_reg;
    events        = 2'h0;
    if (ctrlWr) begin
      // Target and erase option frozen mid-cycle so the target stays traceable
      if (!busy) begin
        selPgm_next   = regWrData[`NVMAC_BIT_PGM];
        selCfg_next   = regWrData[`NVMAC_BIT_CFG];
        rowErase_next = regWrData[`NVMAC_BIT_ERASE];
      end
      write_error_flag_next = regWrData[`NVMAC_BIT_WERR];
      write_enable_bit_next  = regWrData[`NVMAC_BIT_WRITE_ENABLE_BIT];
      // A zero written to write-control is simply dropped
      if (regWrData[`NVMAC_BIT_WR] && !busy) begin
        if (write_enable_bit_next) begin
          state_next = NVMAC_BUSY;
          cnt_next   = '0;
          wrCtl_next = 1'b1;
          mTgt_next  = {selCfg_next, selPgm_next};
          mAddr_next = tablePointer;
          mEr_next   = rowErase_next;
          mWr_next   = !rowErase_next;
        end else begin
          write_error_flag_next = 1'b1;
          events[`NVMAC_EVT_WERR] = 1'b1;
        end
      end else if (regWrData[`NVMAC_BIT_RD] && !busy && !rdCtl_reg
                   && !selPgm_next && !selCfg_next) begin
        rdCtl_next = 1'b1;
        mRd_next   = 1'b1;
        mTgt_next  = 2'h0;
        mAddr_next = tablePointer;
      end
    end
    if (busy) begin
      cnt_next = cnt_reg + `NVMAC_CNT_W'(1);
      if (lastCnt) begin
        state_next    = NVMAC_IDLE;
        wrCtl_next    = 1'b0;
        rowErase_next = 1'b0;
        events[`NVMAC_EVT_DONE] = 1'b1;
      end
    end
    if (!rst_n) begin
      // A warm reset that cuts a cycle short is remembered; targets kept
      if (busy) begin
        write_error_flag_next = 1'b1;
      end
      state_next    = NVMAC_IDLE;
      cnt_next      = '0;
      rowErase_next = 1'b0;
      write_enable_bit_next     = 1'b0;
      wrCtl_next    = 1'b0;
      rdCtl_next    = 1'b0;
      mRd_next      = 1'b0;
      mWr_next      = 1'b0;
      mEr_next      = 1'b0;
      events        = 2'h0;
      if (coldStart) begin
        selPgm_next = 1'b0;
        selCfg_next = 1'b0;
        write_error_flag_next  = 1'b0;
        mTgt_next   = 2'h0;
        mAddr_next  = '0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    state_reg    <= state_next;
    cnt_reg      <= cnt_next;
    selPgm_reg   <= selPgm_next;
    selCfg_reg   <= selCfg_next;
    rowErase_reg <= rowErase_next;
    write_error_flag_reg    <= write_error_flag_next;
    write_enable_bit_reg     <= write_enable_bit_next;
    wrCtl_reg    <= wrCtl_next;
    rdCtl_reg    <= rdCtl_next;
    mRd_reg      <= mRd_next;
    mWr_reg      <= mWr_next;
    mEr_reg      <= mEr_next;
    mTgt_reg     <= mTgt_next;
    mAddr_reg    <= mAddr_next;
  end

  // ==========================================================
  // Events, mask, interrupt and read port
  always_comb begin
    status_next = status_reg;
    mask_next   = mask_reg;
    rdData_next = 8'h00;
    if (regWrite && (regAddr == `NVMAC_OFS_STATUS)) begin
      status_next = status_reg & ~regWrData[1:0];
    end
    if (regWrite && (regAddr == `NVMAC_OFS_MASK)) begin
      mask_next = regWrData[1:0];
    end
    // Set wins over a clear in the same cycle
    status_next = status_next | events;
    if (regRead) begin
      unique case (regAddr)
        `NVMAC_OFS_CTRL: begin
          rdData_next = ctrlPack(selPgm_reg, selCfg_reg, rowErase_reg,
                                 write_error_flag_reg, write_enable_bit_reg, wrCtl_reg, rdCtl_reg);
        end
        `NVMAC_OFS_STATUS: begin
          rdData_next = {6'h00, status_reg};
        end
        `NVMAC_OFS_MASK: begin
          rdData_next = {6'h00, mask_reg};
        end
        default: begin
          rdData_next = 8'h00;
        end
      endcase
    end
    if (!rst_n) begin
      status_next = `NVMAC_EVT_RST;
      mask_next   = `NVMAC_MASK_RST;
      rdData_next = 8'h00;
    end
    irq_next = |(status_next & mask_next);
  end

  always_ff @(posedge core_clk) begin
    status_reg <= status_next;
    mask_reg   <= mask_next;
    rdData_reg <= rdData_next;
    irq_reg    <= irq_next;
  end

  assign regRdData     = rdData_reg;
  assign irq           = irq_reg;
  assign memReadStart  = mRd_reg;
  assign memWriteStart = mWr_reg;
  assign memEraseStart = mEr_reg;
  assign memBusy       = wrCtl_reg;
  assign memTarget     = mTgt_reg;
  assign memRowAddr    = mAddr_reg;

  // ==========================================================
  // Checks
  always_ff @(posedge core_clk) begin
    rdCtlSeen_reg <= regRead && (regAddr == `NVMAC_OFS_CTRL);
  end

  wr_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    busy && lastCnt |=> !wrCtl_reg && !busy)
    else $error("write-control not cleared at end of cycle");

  wr_zero_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    busy && !lastCnt && ctrlWr && !regWrData[`NVMAC_BIT_WR] |=> wrCtl_reg)
    else $error("write of zero cleared write-control");

  rd_pulse_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(rdCtl_reg) |-> memReadStart ##1 !rdCtl_reg)
    else $error("read-control not a one-cycle pulse");

  rd_refuse_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    rdCtl_reg |-> !selPgm_reg && !selCfg_reg)
    else $error("read started with program or config select");

  write_enable_bit_gate_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(wrCtl_reg) |-> write_enable_bit_reg && (memWriteStart || memEraseStart))
    else $error("write started without write enable");

  bad_write_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    ctrlWr && !busy && regWrData[`NVMAC_BIT_WR] && !regWrData[`NVMAC_BIT_WRITE_ENABLE_BIT]
    |=> write_error_flag_reg && !wrCtl_reg && status_reg[`NVMAC_EVT_WERR])
    else $error("improper write not flagged");

  sel_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    busy |=> $stable(selPgm_reg) && $stable(selCfg_reg))
    else $error("target select changed during a write");

  erase_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    busy && lastCnt |=> !rowErase_reg)
    else $error("row-erase not cleared at completion");

  target_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    memWriteStart || memEraseStart |-> memTarget == {selCfg_reg, selPgm_reg})
    else $error("memory target does not follow select bits");

  done_evt_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    busy && lastCnt |=> status_reg[`NVMAC_EVT_DONE] && (irq || !mask_reg[`NVMAC_EVT_DONE]))
    else $error("completion event not raised");

  rsvd_zero_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    rdCtlSeen_reg |-> !regRdData[`NVMAC_BIT_RSVD])
    else $error("reserved control bit read as one");

  irq_level_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    irq == |(status_reg & mask_reg))
    else $error("interrupt does not match status and mask");

endmodule : nvm_access_control
`default_nettype wire

// File: verif/nvm_access_control_tb.sv
// Self-checking testbench of the nonvolatile access control block
`timescale 1ns/1ns
`default_nettype none

module nvm_access_control_tb;
  import nvmac_pkg::*;

  localparam int unsigned NCYC = 8;

  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        coldStart = 1'b1;
  logic [1:0]  regAddr = 2'h0;
  logic [7:0]  regWrData = 8'h00;
  logic        regWrite = 1'b0;
  logic        regRead = 1'b0;
  logic [7:0]  regRdData;
  logic [21:0] tablePointer = 22'h000000;
  logic        memReadStart, memWriteStart, memEraseStart, memBusy, irq;
  logic [1:0]  memTarget;
  logic [21:0] memRowAddr;
  int          fail_count = 0;
  int          num_checks = 0;
  int          busyCnt;
  logic [7:0]  rowIn  [5] = '{8'hC0, 8'hE0, 8'h04, 8'h14, 8'h00};
  logic [7:0]  rowOut [5] = '{8'hC0, 8'hC0, 8'h04, 8'h14, 8'h00};

  nvm_access_control #(.WRITE_CYCLES(NCYC)) u_nvm_access_control (
    .core_clk(core_clk), .rst_n(rst_n), .coldStart(coldStart), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .tablePointer(tablePointer), .memReadStart(memReadStart), .memWriteStart(memWriteStart),
    .memEraseStart(memEraseStart), .memBusy(memBusy), .memTarget(memTarget),
    .memRowAddr(memRowAddr), .irq(irq)
  );

  // ==========================================================
  // Clock and helpers
  initial begin
    forever #25 core_clk = ~core_clk;
  end

  task automatic chk(input string nm, input logic [21:0] exp, input logic [21:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Returns just after the edge that samples the strobe, outputs of that edge settled
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regAddr   <= a;
    regWrData <= d;
    regWrite  <= 1'b1;
    @(posedge core_clk);
    regWrite  <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [1:0] a, input logic [7:0] exp, input string nm);
    @(posedge core_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge core_clk);
    regRead <= 1'b0;
    #1;
    chk(nm, {14'h0000, exp}, {14'h0000, regRdData});
  endtask : rd

  // Bounded wait; spent is the number of edges busy was already seen high
  task automatic wait_done(input int spent);
    busyCnt = spent;
    for (int i = 0; i < 100; i++) begin
      @(posedge core_clk);
      #1;
      if (memBusy === 1'b1) busyCnt++;
      else break;
    end
    if (memBusy !== 1'b0) begin
      fail_count++;
      $display("[FAIL] wait_done expected busy 0 seen %b", memBusy);
    end
  endtask : wait_done

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish

  // ==========================================================
  // Watchdog, far above the hundred or so cycles the tests need
  initial begin
    #2000000;
    fail_count++;
    tally_and_finish();
  end

  // ==========================================================
  // Main sequence
  initial begin
    repeat (12) @(posedge core_clk);
    rst_n     <= 1'b1;
    coldStart <= 1'b0;
    rd(2'h0, 8'h00, "ctrl reset");
    rd(2'h1, 8'h00, "status reset");
    rd(2'h2, 8'h00, "mask reset");
    rd(2'h3, 8'h00, "unmapped");
    for (int r = 0; r < 5; r++) begin
      wr(2'h0, rowIn[r]);
      rd(2'h0, rowOut[r], "ctrl row");
    end
    // One-cycle read, then hardware clears the read bit
    wr(2'h0, 8'h01);
    chk("rdStart", 1, memReadStart);
    chk("rdTarget", 0, memTarget);
    @(posedge core_clk);
    #1;
    chk("rdStart off", 0, memReadStart);
    rd(2'h0, 8'h00, "rd cleared");
    wr(2'h0, 8'h81);
    chk("rd refused pgm", 0, memReadStart);
    wr(2'h0, 8'h41);
    chk("rd refused cfg", 0, memReadStart);
    rd(2'h0, 8'h40, "rd bit held low");
    // Row erase of program flash, with a clear attempt while busy
    wr(2'h2, 8'h01);
    @(posedge core_clk);
    tablePointer <= 22'h2A5C3;
    wr(2'h0, 8'h96);
    chk("erStart", 1, memEraseStart);
    chk("wrStart none", 0, memWriteStart);
    chk("busy", 1, memBusy);
    chk("target pgm", 2'b01, memTarget);
    chk("row addr", 22'h2A5C3, memRowAddr);
    // Other selects and no erase written mid-cycle: all must stay frozen
    wr(2'h0, 8'h44);
    chk("busy after clear", 1, memBusy);
    rd(2'h0, 8'h96, "ctrl busy");
    wait_done(5);
    chk("busy length", NCYC, busyCnt);
    rd(2'h0, 8'h84, "ctrl done");
    rd(2'h1, 8'h01, "done event");
    chk("irq done", 1, irq);
    wr(2'h1, 8'h01);
    chk("irq cleared", 0, irq);
    // Plain EEPROM write and configuration write
    wr(2'h0, 8'h06);
    chk("wrStart ee", 1, memWriteStart);
    chk("target ee", 2'b00, memTarget);
    wait_done(1);
    wr(2'h0, 8'h46);
    chk("target cfg", 2'b10, memTarget);
    wait_done(1);
    // Improper attempt with write enable low
    wr(2'h1, 8'h03);
    wr(2'h2, 8'h02);
    wr(2'h0, 8'h82);
    chk("inhibit wr", 0, memWriteStart);
    chk("inhibit busy", 0, memBusy);
    rd(2'h0, 8'h88, "ctrl improper");
    rd(2'h1, 8'h02, "improper event");
    chk("irq improper", 1, irq);
    // Reset in mid-write keeps selects and flags the error
    wr(2'h0, 8'h46);
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    #1;
    chk("busy reset", 0, memBusy);
    chk("irq reset", 0, irq);
    rd(2'h0, 8'h48, "ctrl after reset");
    tally_and_finish();
  end

endmodule : nvm_access_control_tb

`default_nettype wire
